/* test/host_model.sv */
// host side model: ahb-lite master and fault line monitor
`timescale 1ns/100ps
`default_nettype none
module host_model (
	// clock
	input  wire logic        sys_clk,
	// ahb-lite master side
	output logic             hsel,
	output logic [7:0]       haddr,
	output logic [1:0]       htrans,
	output logic             hwrite,
	output logic [2:0]       hsize,
	output logic [31:0]      hwdata,
	input  wire logic        hready,
	input  wire logic [31:0] hrdata,
	// open-drain fault line with pull-up
	input  wire logic        fault_pin_n
);
	int run;
	int last_low;

	// bus idle at time zero
	initial begin
		hsel = 1'b0;
		haddr = 8'h00;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		run = 0;
		last_low = 0;
	end

	// length of the last low period, in clock cycles
	always @(posedge sys_clk) begin
		if (fault_pin_n === 1'b0) begin
			run <= run + 1;
		end else if (run != 0) begin
			last_low <= run;
			run <= 0;
		end
	end

	// one single word transfer; each phase held until hready is high
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge sys_clk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= 2'h2;
		hwrite <= wr;
		do @(posedge sys_clk); while (hready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wr ? d : ~d;
		do @(posedge sys_clk); while (hready !== 1'b1);
		q = hrdata;
	endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// self-checking bench for the led fault supervision block
`timescale 1ns/100ps
`default_nettype none
module testbench;
	import fault_diag_pkg::*;
	// ---------------------------------------------------------------
	// signals
	// ---------------------------------------------------------------
	logic        sys_clk, reset, hsel, hwrite, hreadyout, hresp;
	logic [7:0]  haddr, cec;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [31:0] hwdata, hrdata;
	logic        rail_uvlo, supply_uv, supply_low, wdt, cmp_fail, pol;
	logic [11:0] opn, sht, sls, pwm, drv, dpe;
	logic [3:0]  lowv_cfg;
	logic        fout, foe;
	wire         fault_pin_n = foe ? fout : 1'b1;
	int          mismatches = 0;
	int          compares = 0;

	typedef struct packed {
		logic [7:0]  a;
		logic [31:0] d;
		logic [31:0] m;
		logic [31:0] e;
	} row_t;
	// write value, read mask, expected read value
	row_t rows [5] = '{
		'{ADDR_CTRL, 32'h0000_0001, 32'hFFFF_FFFF, 32'h0},
		'{ADDR_CHCFG, 32'h0FFF_000F, 32'h0FFF_0FFF, 32'h0FFF_000F},
		'{ADDR_DIAG, 32'h0000_0004, 32'h0000_3FFF, 32'h0000_0004},
		'{8'h20, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'h0},
		'{ADDR_DIAG, 32'h0000_0F04, 32'h0000_3FFF, 32'h0000_0F04}
	};

	// ---------------------------------------------------------------
	// design, host and clock
	// ---------------------------------------------------------------
	led_fault_diag_manager led_fault_diag_manager_inst (
		.sys_clk(sys_clk), .reset(reset), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .rail_uvlo(rail_uvlo),
		.supply_uv(supply_uv), .supply_low(supply_low),
		.out_open_cmp(opn), .out_short_cmp(sht), .out_sls_adc(sls),
		.pwm_on(pwm), .correction_event_count(cec), .wdt_overflow(wdt),
		.cmp_selftest_fail(cmp_fail), .nv_fault_policy_all_off(pol),
		.channel_drive_en(drv), .diag_pulse_en(dpe),
		.low_supply_threshold_cfg(lowv_cfg), .fault_pin_n_out(fout),
		.fault_pin_n_oe(foe));
	host_model host_model_inst (
		.sys_clk(sys_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .fault_pin_n(fault_pin_n));
	always #50 sys_clk = ~sys_clk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e);
		logic [31:0] q;
		host_model_inst.xfer(1'b0, a, 32'h0, q);
		chk(q & m, e);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		host_model_inst.xfer(1'b1, a, d, q);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	function automatic logic [31:0] fb(input int b);
		return 32'h1 << b;
	endfunction
	task automatic stop_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// hang guard, well beyond the expected run length
	initial begin
		repeat (30000) @(posedge sys_clk);
		mismatches++;
		stop_test();
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		reset <= 1'b1;
		{rail_uvlo, supply_uv, supply_low, wdt, cmp_fail, pol} <= 6'h0;
		{opn, sht, sls, pwm} <= 48'h0;
		cec <= 8'h00;
		cyc(12);
		reset <= 1'b0;
		cyc(5);
		chk(drv, 32'h0);
		rdchk(ADDR_FLAGS, 32'h3, 32'h3);
		// comparator self-test after power-on flag clear
		cmp_fail <= 1'b1;
		wr(ADDR_CTRL, fb(CTRL_POR_CLR));
		cyc(10);
		cmp_fail <= 1'b0;
		rdchk(ADDR_FLAGS, 32'h43, 32'h41);
		cyc(600);
		chk(host_model_inst.last_low, PULSE_CYCLES);
		// register rows
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdchk(rows[i].a, rows[i].m, rows[i].e);
		end
		chk(lowv_cfg, 32'hF);
		chk(drv, 32'h00F);
		// low supply latches flags and hides open faults
		supply_low <= 1'b1;
		pwm[0] <= 1'b1;
		opn[0] <= 1'b1;
		cyc(20);
		rdchk(ADDR_FLAGS, 32'h5, 32'h5);
		rdchk(ADDR_CHFLAG, 32'h1, 32'h0);
		{supply_low, opn, pwm} <= 25'h0;
		cyc(600);
		wr(ADDR_CTRL, fb(CTRL_ERR_CLR));
		rdchk(ADDR_FLAGS, 32'h4, 32'h0);
		// short on enabled ch1 counts, on disabled ch8 does not
		pwm <= 12'h102;
		sht <= 12'h102;
		cyc(20);
		rdchk(ADDR_CHFLAG, 32'h0004_0800, 32'h0000_0800);
		rdchk(ADDR_FLAGS, 32'h11, 32'h11);
		{sht, pwm} <= 24'h0;
		cyc(600);
		chk(host_model_inst.last_low, PULSE_CYCLES);
		wr(ADDR_CTRL, fb(CTRL_ERR_CLR));
		// auto single-led scan with output flag and pulse masked
		wr(ADDR_DIAG, 32'h0000_3F04);
		pwm[0] <= 1'b1;
		sls[0] <= 1'b1;
		cyc(20);
		chk(foe, 32'h0);
		rdchk(ADDR_CHFLAG, 32'h0010_0000, 32'h0010_0000);
		rdchk(ADDR_FLAGS, 32'h11, 32'h0);
		{sls, pwm} <= 24'h0;
		wr(ADDR_DIAG, 32'h0000_0F04);
		wr(ADDR_CTRL, fb(CTRL_ERR_CLR));
		// correction event with a second request mid-pulse
		cec <= 8'h03;
		cyc(100);
		cec <= 8'h00;
		cyc(1);
		cec <= 8'h05;
		cyc(500);
		rdchk(ADDR_FLAGS, 32'h21, 32'h21);
		chk(host_model_inst.last_low, PULSE_CYCLES);
		cec <= 8'h00;
		// supply undervoltage holds the line and drops all outputs
		supply_uv <= 1'b1;
		cyc(30);
		chk({foe, drv}, 32'h1000);
		supply_uv <= 1'b0;
		cyc(3);
		chk({foe, drv}, 32'h000F);
		rdchk(ADDR_FLAGS, 32'h9, 32'h9);
		cyc(600);
		// invisible diagnostic on disabled ch5 with an open output
		opn[5] <= 1'b1;
		wr(ADDR_CTRL, fb(CTRL_INV_START));
		cyc(2);
		chk(dpe, 32'hFF0);
		cyc(48);
		rdchk(ADDR_FLAGS, fb(FLG_ODR) | 32'h11, fb(FLG_ODR) | 32'h11);
		rdchk(ADDR_CHFLAG, 32'h20, 32'h20);
		opn[5] <= 1'b0;
		cyc(600);
		// single-led check on ch6 flags only above low supply
		supply_low <= 1'b1;
		sls[6] <= 1'b1;
		wr(ADDR_CTRL, fb(CTRL_SLS_START));
		cyc(50);
		rdchk(ADDR_CHFLAG, 32'h0400_0000, 32'h0);
		supply_low <= 1'b0;
		wr(ADDR_CTRL, fb(CTRL_SLS_START));
		cyc(50);
		rdchk(ADDR_CHFLAG, 32'h0400_0000, 32'h0400_0000);
		sls[6] <= 1'b0;
		cyc(600);
		// watchdog overflow: fail-safe without fault line action
		wdt <= 1'b1;
		cyc(1);
		wdt <= 1'b0;
		cyc(20);
		chk(foe, 32'h0);
		rdchk(ADDR_FLAGS, fb(FLG_FS), fb(FLG_FS));
		chk(hresp, 32'h0);
		pwm <= 12'hFFF;
		sht[2] <= 1'b1;
		cyc(20);
		chk(drv, 32'h00B);
		pol <= 1'b1;
		sht[3] <= 1'b1;
		cyc(20);
		chk(drv, 32'h000);
		{sht, pwm, pol} <= 25'h0;
		cyc(600);
		wr(ADDR_CTRL, fb(CTRL_FS_CLR));
		rdchk(ADDR_FLAGS, fb(FLG_FS), 32'h0);
		// rail lockout and recovery
		wr(ADDR_CTRL, fb(CTRL_POR_CLR));
		rail_uvlo <= 1'b1;
		cyc(5);
		rail_uvlo <= 1'b0;
		cyc(10);
		rdchk(ADDR_FLAGS, 32'h3, 32'h3);
		// second reset in mid-run drops the channel setup
		reset <= 1'b1;
		cyc(3);
		reset <= 1'b0;
		cyc(5);
		chk(drv, 32'h0);
		rdchk(ADDR_CHCFG, 32'hFFFF_FFFF, 32'h0);
		rdchk(ADDR_FLAGS, 32'h1FF, 32'h3);
		stop_test();
	end
endmodule
`default_nettype wire

/* verilog/fault_diag_pkg.sv */
// constants for the led fault supervision block
package fault_diag_pkg;
	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_FLAGS   = 8'h04;
	localparam logic [7:0] ADDR_CHFLAG  = 8'h08;
	localparam logic [7:0] ADDR_CHCFG   = 8'h0C;
	localparam logic [7:0] ADDR_DIAG    = 8'h10;
	localparam logic [7:0] ADDR_STATE   = 8'h14;
	// ---------------------------------------------------------------
	// ctrl register fields (write one, self clearing)
	// ---------------------------------------------------------------
	localparam int CTRL_ERR_CLR   = 0;
	localparam int CTRL_POR_CLR   = 1;
	localparam int CTRL_FS_CLR    = 2;
	localparam int CTRL_INV_START = 3;
	localparam int CTRL_SLS_START = 4;
	// ---------------------------------------------------------------
	// summary flag register fields
	// ---------------------------------------------------------------
	localparam int FLG_ERR  = 0;
	localparam int FLG_POR  = 1;
	localparam int FLG_LOWV = 2;
	localparam int FLG_UV   = 3;
	localparam int FLG_OUT  = 4;
	localparam int FLG_ECC  = 5;
	localparam int FLG_CMP  = 6;
	localparam int FLG_FS   = 7;
	localparam int FLG_ODR  = 8;
	localparam int FLG_W    = 9;
	// ---------------------------------------------------------------
	// diag config register fields
	// ---------------------------------------------------------------
	localparam int DIAG_PW_LSB  = 0;
	localparam int DIAG_PW_W    = 8;
	localparam int DIAG_LOWV_LSB = 8;
	localparam int DIAG_LOWV_W  = 4;
	localparam int DIAG_AUTO    = 12;
	localparam int DIAG_MASK_OUT = 13;
	localparam logic [31:0] DIAG_RESET = 32'h0000_0010;
	// threshold code 0 is 4 V, code 15 is 19 V, one volt per step
	localparam int LOWV_MIN_V = 4;
	localparam int LOWV_MAX_V = 19;
	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_HZ         = 10_000_000;
	localparam int PULSE_US       = 50;
	localparam int PULSE_CYCLES   = PULSE_US * (CLK_HZ / 1_000_000);
	localparam int NUM_CH         = 12;
	// ---------------------------------------------------------------
	// device states
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {ST_POR, ST_INIT, ST_NORMAL, ST_FAILSAFE}
		dev_state_t;
endpackage

/* verilog/led_fault_diag_manager.sv */
// fault supervision, fault pin timing and on-demand diagnostics
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - in fail-safe, policy bit one makes any led fault take all-off policy
// - all-off policy disables every channel on any led fault anywhere
// - in fail-safe, without policy bit only the faulty channel is disabled
// - flag registers stay readable on the bus in fail-safe state
// - rail lockout forces power-on state; recovery goes to init, por+err
// - supply below threshold latches low-supply flag and error flag
// - error-clear bit self-clears and always reads back zero
// - low supply suppresses open (except invisible diagnostic) and single-led short detection
// - low-supply threshold code spans 4 V to 19 V
// - undervoltage holds fault pin low, sets flags, disables all outputs
// - above rising threshold outputs return alone; flags stay latched
// - undervoltage recovery releases constant pull-down without host
// - short check (except invisible diagnostic) only on enabled diag channel with pulse over width
// - nonzero correction count sets flags and one 50 us pulse
// - invisible diagnostic on disabled channel sets ready and fault flags
// - single-led check on disabled channel flags only above low supply
// - watchdog overflow enters fail-safe; fail-safe clear returns normal
// - failed comparator self-test sets flags and one 50 us pulse
module led_fault_diag_manager
	import fault_diag_pkg::*;
#(
	parameter int N_CH = NUM_CH
) (
	// clock and reset
	input  wire logic            sys_clk,
	input  wire logic            reset,
	// ahb-lite slave
	input  wire logic            hsel,
	input  wire logic [7:0]      haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic      [31:0]     hrdata,
	output logic                 hreadyout,
	output logic                 hresp,
	// analog and monitor indications
	input  wire logic            rail_uvlo,
	input  wire logic            supply_uv,
	input  wire logic            supply_low,
	input  wire logic [N_CH-1:0] out_open_cmp,
	input  wire logic [N_CH-1:0] out_short_cmp,
	input  wire logic [N_CH-1:0] out_sls_adc,
	input  wire logic [N_CH-1:0] pwm_on,
	input  wire logic [7:0]      correction_event_count,
	input  wire logic            wdt_overflow,
	input  wire logic            cmp_selftest_fail,
	input  wire logic            nv_fault_policy_all_off,
	// channel drive and fault pin
	output logic      [N_CH-1:0] channel_drive_en,
	output logic      [N_CH-1:0] diag_pulse_en,
	output logic      [3:0]      low_supply_threshold_cfg,
	output logic                 fault_pin_n_out,
	output logic                 fault_pin_n_oe
);
	// ---------------------------------------------------------------
	// state and storage
	// ---------------------------------------------------------------
	dev_state_t        state;
	dev_state_t        next_state;
	logic [FLG_W-1:0]  flags;
	logic [N_CH-1:0]   flag_channel_open;
	logic [N_CH-1:0]   flag_channel_short;
	logic [N_CH-1:0]   flag_channel_ondemand_fault;
	logic [N_CH-1:0]   channel_enable_cfg;
	logic [N_CH-1:0]   channel_diag_enable_cfg;
	logic [31:0]       diag_cfg;
	logic [N_CH-1:0]   pw_ok;
	logic [7:0]        pw_cnt [N_CH];
	logic [15:0]       pulse_cnt;
	logic              od_busy;
	logic              od_is_sls;
	logic [7:0]        od_cnt;
	logic              cmp_pending;
	logic              ecc_seen;
	logic              wr_pend;
	logic [7:0]        wr_addr;
	// ---------------------------------------------------------------
	// bus decode
	// ---------------------------------------------------------------
	wire         addr_ph  = hsel & hready & htrans[1];
	wire         wr_go    = wr_pend;
	wire [31:0]  wd       = hwdata;
	wire         ctl_wr   = wr_go & (wr_addr == ADDR_CTRL);
	wire         err_clr  = ctl_wr & wd[CTRL_ERR_CLR];
	wire         por_clr  = ctl_wr & wd[CTRL_POR_CLR];
	wire         fs_clr   = ctl_wr & wd[CTRL_FS_CLR];
	wire         inv_go   = ctl_wr & wd[CTRL_INV_START];
	wire         sls_go   = ctl_wr & wd[CTRL_SLS_START];
	wire [7:0]   pw_cfg   = diag_cfg[DIAG_PW_LSB +: DIAG_PW_W];
	wire         mask_out = diag_cfg[DIAG_MASK_OUT];
	wire         failsafe = (state == ST_FAILSAFE);
	// ---------------------------------------------------------------
	// fault qualification
	// ---------------------------------------------------------------
	wire [N_CH-1:0] diag_ok = channel_enable_cfg & channel_diag_enable_cfg;
	// open/sls are blanked in low supply
	wire [N_CH-1:0] open_ev = supply_low ? '0 :
		(out_open_cmp & diag_ok & pw_ok);
	wire [N_CH-1:0] short_ev = out_short_cmp & diag_ok & pw_ok;
	wire [N_CH-1:0] sls_ev = (supply_low | ~diag_cfg[DIAG_AUTO]) ? '0 :
		(out_sls_adc & diag_ok & pw_ok);
	wire [N_CH-1:0] od_sel = ~channel_enable_cfg & channel_diag_enable_cfg;
	wire            od_end = od_busy & (od_cnt >= pw_cfg);
	wire [N_CH-1:0] od_open  = od_end & ~od_is_sls ?
		(od_sel & out_open_cmp) : '0;
	wire [N_CH-1:0] od_short = od_end & ~od_is_sls ?
		(od_sel & out_short_cmp) : '0;
	wire [N_CH-1:0] od_sls = (od_end & od_is_sls & ~supply_low) ?
		(od_sel & out_sls_adc) : '0;
	wire [N_CH-1:0] ch_fault = flag_channel_open | flag_channel_short |
		flag_channel_ondemand_fault;
	wire            led_ev  = |(open_ev | short_ev | sls_ev);
	wire            od_ev   = |(od_open | od_short | od_sls);
	wire            ecc_ev  = (correction_event_count != 8'h00) & ~ecc_seen;
	wire            cmp_ev  = cmp_pending & cmp_selftest_fail;
	wire            lowv_ev = supply_low & ~flags[FLG_LOWV];
	// pulse requests for one timed low pulse
	wire            pulse_req = (led_ev & ~mask_out) | od_ev | od_end |
		ecc_ev | cmp_ev | lowv_ev;
	// all-off policy only acts in fail-safe
	wire            all_off = failsafe & nv_fault_policy_all_off &
		(|ch_fault);
	// per-channel gating and global undervoltage
	wire [N_CH-1:0] next_drive = (supply_uv | all_off |
		(state != ST_NORMAL && !failsafe)) ? '0 :
		(failsafe ? channel_enable_cfg & ~ch_fault
		: channel_enable_cfg);
	// ---------------------------------------------------------------
	// device state machine
	// ---------------------------------------------------------------
	always_comb begin
		next_state = state;
		case (state)
			ST_POR:      next_state = ST_INIT;
			ST_INIT:     next_state = ST_NORMAL;
			ST_NORMAL:   if (wdt_overflow) next_state = ST_FAILSAFE;
			ST_FAILSAFE: if (fs_clr) next_state = ST_NORMAL;
			default:     next_state = ST_POR;
		endcase
		if (rail_uvlo)
			next_state = ST_POR;
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			state <= ST_POR;
		else
			state <= next_state;
	end
	// ---------------------------------------------------------------
	// summary flags: set wins over clear
	// ---------------------------------------------------------------
	logic [FLG_W-1:0] fset;
	logic [FLG_W-1:0] fclr;
	always_comb begin
		fset = '0;
		fclr = '0;
		fset[FLG_POR]  = state == ST_POR;
		fset[FLG_LOWV] = supply_low | supply_uv;
		fset[FLG_UV]   = supply_uv;
		fset[FLG_OUT]  = (led_ev & ~mask_out) | od_ev;
		fset[FLG_ECC]  = ecc_ev;
		fset[FLG_CMP]  = cmp_ev;
		fset[FLG_FS]   = state == ST_NORMAL && wdt_overflow;
		fset[FLG_ODR]  = od_end;
		fset[FLG_ERR]  = (|fset[FLG_CMP:FLG_LOWV]) | fset[FLG_POR] | od_end;
		// error clear removes latched flags once conditions are gone
		if (err_clr)
			fclr = ~(FLG_W'(1) << FLG_POR) & ~(FLG_W'(1) << FLG_FS);
		fclr[FLG_POR] = por_clr;
		fclr[FLG_ERR] = fclr[FLG_ERR] | por_clr;
		fclr[FLG_FS]  = fs_clr;
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			flags <= '0;
		else
			flags <= (flags & ~fclr) | fset;
	end
	// ---------------------------------------------------------------
	// per-channel flags
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			flag_channel_open           <= '0;
			flag_channel_short          <= '0;
			flag_channel_ondemand_fault <= '0;
		end else begin
			flag_channel_open  <= (err_clr ? '0 : flag_channel_open) |
				open_ev | od_open;
			flag_channel_short <= (err_clr ? '0 : flag_channel_short) |
				short_ev | od_short;
			flag_channel_ondemand_fault <=
				(err_clr ? '0 : flag_channel_ondemand_fault) |
				sls_ev | od_open | od_short | od_sls;
		end
	end
	// ---------------------------------------------------------------
	// pwm on-time qualification against programmed width
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		for (int i = 0; i < N_CH; i++) begin
			if (reset || !pwm_on[i])
				pw_cnt[i] <= 8'h00;
			else if (pw_cnt[i] != 8'hFF)
				pw_cnt[i] <= pw_cnt[i] + 8'h01;
		end
	end
	always_comb begin
		for (int i = 0; i < N_CH; i++)
			pw_ok[i] = pwm_on[i] && (pw_cnt[i] > pw_cfg);
	end
	// ---------------------------------------------------------------
	// on-demand diagnostics sequencer
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			od_busy   <= 1'b0;
			od_is_sls <= 1'b0;
			od_cnt    <= 8'h00;
		end else if (od_busy) begin
			od_cnt  <= od_cnt + 8'h01;
			od_busy <= !od_end;
		end else if (inv_go || sls_go) begin
			od_busy   <= 1'b1;
			od_is_sls <= sls_go & ~inv_go;
			od_cnt    <= 8'h00;
		end
	end
	// test pulse on disabled diag channels
	always_ff @(posedge sys_clk) begin
		if (reset)
			diag_pulse_en <= '0;
		else
			diag_pulse_en <= (od_busy & ~od_end) ? od_sel : '0;
	end
	// ---------------------------------------------------------------
	// self-test arming and correction edge memory
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			cmp_pending <= 1'b0;
			ecc_seen    <= 1'b0;
		end else begin
			cmp_pending <= por_clr ? 1'b1 : 1'b0;
			ecc_seen    <= correction_event_count != 8'h00;
		end
	end
	// ---------------------------------------------------------------
	// fault pin: timed pulse or constant pull-down
	// ---------------------------------------------------------------
	wire const_low = supply_uv | state == ST_POR;
	always_ff @(posedge sys_clk) begin
		if (reset)
			pulse_cnt <= '0;
		else if (pulse_cnt != 16'h0000)
			pulse_cnt <= pulse_cnt - 16'h0001;
		else if (pulse_req && !const_low)
			pulse_cnt <= 16'(PULSE_CYCLES);
	end
	// pin data stays low; only the enable moves
	always_ff @(posedge sys_clk) begin
		if (reset)
			fault_pin_n_oe <= 1'b0;
		else
			fault_pin_n_oe <= const_low || pulse_cnt != 16'h0000;
		fault_pin_n_out <= 1'b0;
	end
	// ---------------------------------------------------------------
	// channel outputs
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset)
			channel_drive_en <= '0;
		else
			channel_drive_en <= next_drive;
	end
	// ---------------------------------------------------------------
	// bus writes: data phase after address phase
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			wr_pend <= 1'b0;
			wr_addr <= 8'h00;
		end else begin
			wr_pend <= addr_ph & hwrite;
			wr_addr <= haddr;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset) begin
			channel_enable_cfg      <= '0;
			channel_diag_enable_cfg <= '0;
			diag_cfg                <= DIAG_RESET;
		end else if (wr_go && wr_addr == ADDR_CHCFG) begin
			channel_enable_cfg      <= wd[N_CH-1:0];
			channel_diag_enable_cfg <= wd[16 +: N_CH];
		end else if (wr_go && wr_addr == ADDR_DIAG) begin
			diag_cfg <= {18'h0, wd[13:0]};
		end
	end
	always_ff @(posedge sys_clk) begin
		if (reset)
			low_supply_threshold_cfg <= 4'h0;
		else
			low_supply_threshold_cfg <=
				diag_cfg[DIAG_LOWV_LSB +: DIAG_LOWV_W];
	end
	// ---------------------------------------------------------------
	// bus reads: readable in every state, ctrl reads zero
	// ---------------------------------------------------------------
	logic [31:0] rd_mux;
	always_comb begin
		case (haddr)
			ADDR_CTRL:   rd_mux = 32'h0000_0000;
			ADDR_FLAGS:  rd_mux = {23'h0, flags};
			ADDR_CHFLAG: rd_mux = {4'h0, flag_channel_ondemand_fault[7:0],
				flag_channel_short[9:0], flag_channel_open[9:0]};
			ADDR_CHCFG:  rd_mux = {4'h0, channel_diag_enable_cfg,
				4'h0, channel_enable_cfg};
			ADDR_DIAG:   rd_mux = diag_cfg;
			ADDR_STATE:  rd_mux = {30'h0, state};
			default:     rd_mux = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge sys_clk) begin
		hreadyout <= 1'b1;
		hresp     <= 1'b0;
		if (reset)
			hrdata <= 32'h0000_0000;
		else if (addr_ph && !hwrite)
			hrdata <= rd_mux;
	end
	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	property p_uv_drive;
		@(posedge sys_clk) disable iff (reset)
		supply_uv |=> channel_drive_en == '0 && fault_pin_n_oe;
	endproperty
	a_uv_drive: assert property (p_uv_drive)
		else $error("outputs not off under undervoltage");
	property p_pulse_len;
		@(posedge sys_clk) disable iff (reset)
		$rose(pulse_cnt != 16'h0000) |-> pulse_cnt == 16'(PULSE_CYCLES);
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("fault pulse length wrong");
	property p_ctrl_zero;
		@(posedge sys_clk) disable iff (reset)
		addr_ph && !hwrite && haddr == ADDR_CTRL |=> hrdata == 32'h0;
	endproperty
	a_ctrl_zero: assert property (p_ctrl_zero)
		else $error("clear bits did not read zero");
	property p_lowv;
		@(posedge sys_clk) disable iff (reset)
		supply_low |=> flags[FLG_LOWV] && flags[FLG_ERR];
	endproperty
	a_lowv: assert property (p_lowv)
		else $error("low supply flag not set");
	property p_fs_enter;
		@(posedge sys_clk) disable iff (reset)
		state == ST_NORMAL && wdt_overflow && !rail_uvlo |=>
			state == ST_FAILSAFE && flags[FLG_FS];
	endproperty
	a_fs_enter: assert property (p_fs_enter)
		else $error("fail-safe not entered");
	property p_alloff;
		@(posedge sys_clk) disable iff (reset)
		all_off |=> channel_drive_en == '0;
	endproperty
	a_alloff: assert property (p_alloff)
		else $error("all-off policy not applied");
	property p_por_init;
		@(posedge sys_clk) disable iff (reset)
		state == ST_POR && !rail_uvlo |=> state == ST_INIT && flags[FLG_POR];
	endproperty
	a_por_init: assert property (p_por_init)
		else $error("no move to init after lockout");
	property p_uv_release;
		@(posedge sys_clk) disable iff (reset)
		$fell(supply_uv) && state != ST_POR && pulse_cnt == 16'h0000
			|=> !fault_pin_n_oe;
	endproperty
	a_uv_release: assert property (p_uv_release)
		else $error("pull-down not released");
	c_pulse: cover property (@(posedge sys_clk) $rose(pulse_cnt != 16'h0));
	c_fs:    cover property (@(posedge sys_clk) fs_clr && failsafe);
	c_od:    cover property (@(posedge sys_clk) od_end);
endmodule
`default_nettype wire
